/* File: gpio_logic_pkg.sv */
package gpio_logic_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] OFS_TABLE_ONE_OUT_UPPER = 8'h26;
  localparam logic [7:0] OFS_TABLE_ONE_OUT_LOWER = 8'h27;
  localparam logic [7:0] OFS_TABLE_TWO_OUT_UPPER_A = 8'h28;
  localparam logic [7:0] OFS_TABLE_TWO_OUT_LOWER_A = 8'h29;
  localparam logic [7:0] OFS_TABLE_TWO_OUT_UPPER_B = 8'h2A;
  localparam logic [7:0] OFS_TABLE_TWO_OUT_LOWER_B = 8'h2B;
  localparam int unsigned TABLE_COUNT = 6;

  // reset value of every truth table
  localparam logic [7:0] TABLE_RESET = 8'h00;

  // read data for an unmapped offset
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // per-bank logic mode
  typedef enum logic [1:0] {
    logic_off,
    logic_three_one,
    logic_three_two,
    logic_other
  } logic_mode_t;

  // one access from the serial port's byte engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // one pin as seen by the pad: level plus enable
  typedef struct packed {
    logic value;
    logic oe;
  } pin_drive_t;

endpackage

/* File: logic_bank.sv */
`timescale 1ns/1ps
module logic_bank
  import gpio_logic_pkg::*;
#(
  parameter int SEL_W = 3
)
(
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // pins feeding the selector
  input  wire logic [SEL_W-1:0]      pins_i,
  // settings
  input  wire logic_mode_t           mode_i,
  input  wire logic [2**SEL_W-1:0]   table_one_i,
  input  wire logic [2**SEL_W-1:0]   table_two_a_i,
  input  wire logic [2**SEL_W-1:0]   table_two_b_i,
  // outputs
  output pin_drive_t                 first_o,
  output pin_drive_t                 second_o,
  output logic [SEL_W-1:0]           pattern_o
);

  if (SEL_W < 1 || SEL_W > 3)
  begin : g_bad_width
    $error("logic_bank: SEL_W must be 1 to 3");
  end

  logic [SEL_W-1:0] sync_a;
  logic [SEL_W-1:0] sync_b;
  logic [SEL_W-1:0] sync_c;
  logic [SEL_W-1:0] next_pattern;
  pin_drive_t       next_first;
  pin_drive_t       next_second;

  // a pin change counts only once the last two stages agree
  always_comb
  begin
    next_pattern = pattern_o;
    if (sync_b == sync_c)
    begin
      next_pattern = sync_c;
    end
  end

  always_comb
  begin
    next_first  = '0;
    next_second = '0;
    case (mode_i)
      logic_three_one:
      begin
        next_first.value = table_one_i[pattern_o];
        next_first.oe    = 1'b1;
      end
      logic_three_two:
      begin
        next_first.value  = table_two_a_i[pattern_o];
        next_first.oe     = 1'b1;
        next_second.value = table_two_b_i[pattern_o];
        next_second.oe    = 1'b1;
      end
      default:
      begin
        // tables stay stored but reach no pin
        next_first  = '0;
        next_second = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_c    <= '0;
      pattern_o <= '0;
      first_o   <= '0;
      second_o  <= '0;
    end
    else
    begin
      sync_a    <= pins_i;
      sync_b    <= sync_a;
      sync_c    <= sync_b;
      pattern_o <= next_pattern;
      first_o   <= next_first;
      second_o  <= next_second;
    end
  end

endmodule // logic_bank

/* File: gpio_logic_lut.sv */
`timescale 1ns/1ps
module gpio_logic_lut
  import gpio_logic_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // serial register port accesses
  input  reg_req_t         req_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  // logic mode per bank
  input  wire logic_mode_t upper_bank_logic_mode_i,
  input  wire logic_mode_t lower_bank_logic_mode_i,
  // input pins
  input  wire logic [2:0]  io_upper_sel_i,
  input  wire logic [2:0]  io_lower_sel_i,
  // driven pins
  output logic             io11_o,
  output logic             io11_oe_o,
  output logic             io12_o,
  output logic             io12_oe_o,
  output logic             io3_o,
  output logic             io3_oe_o,
  output logic             io4_o,
  output logic             io4_oe_o
);

  logic [7:0] tables [TABLE_COUNT];
  logic [7:0] next_tables [TABLE_COUNT];
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       addr_hit;
  logic [2:0] addr_idx;
  logic [2:0] pattern_up;
  logic [2:0] pattern_lo;
  pin_drive_t up_first;
  pin_drive_t up_second;
  pin_drive_t lo_first;
  pin_drive_t lo_second;

  // tables sit at six consecutive offsets, index = offset - first
  always_comb
  begin
    addr_hit = 1'b0;
    addr_idx = 3'h0;
    if (req_i.addr >= OFS_TABLE_ONE_OUT_UPPER && req_i.addr <= OFS_TABLE_TWO_OUT_LOWER_B)
    begin
      addr_hit = 1'b1;
      addr_idx = 3'(req_i.addr - OFS_TABLE_ONE_OUT_UPPER);
    end
  end

  always_comb
  begin
    next_tables = tables;
    next_rvalid = req_i.rd;
    next_rdata  = rdata_o;
    if (req_i.wr && addr_hit)
    begin
      next_tables[addr_idx] = req_i.wdata;
    end
    if (req_i.rd)
    begin
      next_rdata = addr_hit ? tables[addr_idx] : UNMAPPED_READ;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < TABLE_COUNT; i++)
      begin
        tables[i] <= TABLE_RESET;
      end
      rdata_o  <= UNMAPPED_READ;
      rvalid_o <= 1'b0;
    end
    else
    begin
      tables   <= next_tables;
      rdata_o  <= next_rdata;
      rvalid_o <= next_rvalid;
    end
  end

  // upper bank: io 10..8 select, io 11 and io 12 driven
  logic_bank #(
    .SEL_W (3)
  ) u_upper (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .pins_i        (io_upper_sel_i),
    .mode_i        (upper_bank_logic_mode_i),
    .table_one_i   (tables[0]),
    .table_two_a_i (tables[2]),
    .table_two_b_i (tables[4]),
    .first_o       (up_first),
    .second_o      (up_second),
    .pattern_o     (pattern_up)
  );

  // lower bank: io 2..0 select, io 3 and io 4 driven
  logic_bank #(
    .SEL_W (3)
  ) u_lower (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .pins_i        (io_lower_sel_i),
    .mode_i        (lower_bank_logic_mode_i),
    .table_one_i   (tables[1]),
    .table_two_a_i (tables[3]),
    .table_two_b_i (tables[5]),
    .first_o       (lo_first),
    .second_o      (lo_second),
    .pattern_o     (pattern_lo)
  );

  // bank outputs are already flip-flops, so pins stay registered
  assign io11_o    = up_first.value;
  assign io11_oe_o = up_first.oe;
  assign io12_o    = up_second.value;
  assign io12_oe_o = up_second.oe;
  assign io3_o     = lo_first.value;
  assign io3_oe_o  = lo_first.oe;
  assign io4_o     = lo_second.value;
  assign io4_oe_o  = lo_second.oe;

  // checking helpers
  logic       up_written;
  logic [7:0] up_table;
  logic [7:0] lo_table;
  assign up_table = tables[0];
  assign lo_table = tables[1];

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up_written <= 1'b0;
    end
    else if (req_i.wr && req_i.addr == OFS_TABLE_ONE_OUT_UPPER)
    begin
      up_written <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_upper_lut_drive: assert property (
    upper_bank_logic_mode_i == logic_three_one
      |=> io11_oe_o && io11_o == $past(up_table[pattern_up]))
    else $error("io11 does not follow upper one-out table");

  a_upper_mode_gate: assert property (
    upper_bank_logic_mode_i inside {logic_off, logic_other} |=> !io11_oe_o && !io12_oe_o)
    else $error("io11 driven outside a logic mode");

  a_lower_lut_drive: assert property (
    lower_bank_logic_mode_i == logic_three_one
      |=> io3_oe_o && io3_o == $past(lo_table[pattern_lo]))
    else $error("io3 does not follow lower one-out table");

  a_lower_mode_gate: assert property (
    lower_bank_logic_mode_i != logic_three_one && lower_bank_logic_mode_i != logic_three_two
      |=> !io3_oe_o && !io4_oe_o)
    else $error("io3 driven outside a logic mode");

  a_table_reset_zero: assert property (
    req_i.rd && req_i.addr == OFS_TABLE_ONE_OUT_UPPER && !up_written |=> rdata_o == 8'h00)
    else $error("upper one-out table not zero after reset");

  a_second_out_drive: assert property (
    upper_bank_logic_mode_i == logic_three_two
      |=> io12_oe_o && io12_o == $past(tables[4][pattern_up]))
    else $error("io12 does not follow its table");

  a_table_value_hold: assert property (
    !(req_i.wr && req_i.addr == OFS_TABLE_ONE_OUT_LOWER) |=> $stable(lo_table))
    else $error("lower one-out table changed without a write");

  a_sync_pattern_settle: assert property (
    $stable(io_upper_sel_i) [*5] |=> pattern_up == $past(io_upper_sel_i, 2))
    else $error("upper select pattern not settled");

  a_unmapped_read_zero: assert property (
    req_i.rd && !addr_hit |=> rvalid_o && rdata_o == UNMAPPED_READ)
    else $error("unmapped read not zero");

  a_upper_reset_low: assert property (
    upper_bank_logic_mode_i == logic_three_one && !up_written |=> io11_oe_o && !io11_o)
    else $error("io11 high before any upper one-out table write");

  a_upper_table_hold: assert property (
    !(req_i.wr && req_i.addr == OFS_TABLE_ONE_OUT_UPPER) |=> $stable(up_table))
    else $error("upper one-out table changed without a write");

  a_lower_second_drive: assert property (
    lower_bank_logic_mode_i == logic_three_two
      |=> io4_oe_o && io4_o == $past(tables[5][pattern_lo]))
    else $error("io4 does not follow its table");

  c_upper_three_one: cover property (
    upper_bank_logic_mode_i == logic_three_one ##1 io11_o);
  c_lower_three_one: cover property (
    lower_bank_logic_mode_i == logic_three_one ##1 io3_o);
  c_upper_three_two: cover property (
    upper_bank_logic_mode_i == logic_three_two ##1 io12_o);
  c_table_write_read: cover property (
    req_i.wr && addr_hit ##1 req_i.rd ##1 rvalid_o && rdata_o != 8'h00);
  c_lower_three_two: cover property (
    lower_bank_logic_mode_i == logic_three_two ##1 io4_o);

endmodule // gpio_logic_lut

/* File: gpio_logic_lut_tb.sv */
`timescale 1ns/1ps
module gpio_logic_lut_tb;
  import gpio_logic_pkg::*;

  logic        clock_i;
  logic        rst_i;
  reg_req_t    req;
  logic [7:0]  rdata;
  logic        rvalid;
  logic_mode_t up_mode;
  logic_mode_t lo_mode;
  logic [2:0]  up_sel;
  logic [2:0]  lo_sel;
  logic        io11, io11_oe, io12, io12_oe, io3, io3_oe, io4, io4_oe;
  logic [7:0]  sh [6];
  int          fail_count;
  int          n_compared;

  gpio_logic_lut i_gpio_logic_lut (
    .clock_i                 (clock_i),
    .rst_i                   (rst_i),
    .req_i                   (req),
    .rdata_o                 (rdata),
    .rvalid_o                (rvalid),
    .upper_bank_logic_mode_i (up_mode),
    .lower_bank_logic_mode_i (lo_mode),
    .io_upper_sel_i          (up_sel),
    .io_lower_sel_i          (lo_sel),
    .io11_o                  (io11),
    .io11_oe_o               (io11_oe),
    .io12_o                  (io12),
    .io12_oe_o               (io12_oe),
    .io3_o                   (io3),
    .io3_oe_o                (io3_oe),
    .io4_o                   (io4),
    .io4_oe_o                (io4_oe)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes change on the falling edge; an idle cycle follows each single access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clock_i);
    req = '0;
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock_i);
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
    req = '0;
    @(negedge clock_i);
    // valid stands one cycle, data until the next read
    check({7'h00, rvalid}, 8'h00);
    check(rdata, exp);
  endtask

  // six writes on consecutive edges; the strobe stays up between them
  task automatic write_burst();
    for (int k = 0; k < 6; k++)
    begin
      req = '{1'b1, 1'b0, OFS_TABLE_ONE_OUT_UPPER + 8'(k), sh[k]};
      @(negedge clock_i);
    end
    req = '0;
    @(negedge clock_i);
  endtask

  function automatic logic [1:0] pin_exp(logic_mode_t m, logic second, logic [7:0] one,
                                          logic [7:0] a, logic [7:0] b, logic [2:0] idx);
    if (m == logic_three_one && !second)
      return {1'b1, one[idx]};
    if (m == logic_three_two)
      return {1'b1, second ? b[idx] : a[idx]};
    return 2'b00;
  endfunction

  // every pattern on both banks; lower bank gets the inverted pattern
  task automatic sweep(input logic_mode_t mu, input logic_mode_t ml);
    up_mode = mu;
    lo_mode = ml;
    for (int i = 0; i < 8; i++)
    begin
      up_sel = 3'(i);
      lo_sel = ~3'(i);
      // synchroniser plus output register: five edges; the sweep waits six
      repeat (6) @(negedge clock_i);
      check({6'h00, io11_oe, io11},
            {6'h00, pin_exp(mu, 1'b0, sh[0], sh[2], sh[4], up_sel)});
      check({6'h00, io12_oe, io12},
            {6'h00, pin_exp(mu, 1'b1, sh[0], sh[2], sh[4], up_sel)});
      check({6'h00, io3_oe, io3},
            {6'h00, pin_exp(ml, 1'b0, sh[1], sh[3], sh[5], lo_sel)});
      check({6'h00, io4_oe, io4},
            {6'h00, pin_exp(ml, 1'b1, sh[1], sh[3], sh[5], lo_sel)});
    end
  endtask

  task automatic read_all();
    for (int k = 0; k < 6; k++)
      rd(OFS_TABLE_ONE_OUT_UPPER + 8'(k), sh[k]);
  endtask

  // second reset in mid-run, with tables written and pins driven
  task automatic mid_reset();
    rst_i = 1'b1;
    @(negedge clock_i);
    check({io11_oe, io11, io12_oe, io12, io3_oe, io3, io4_oe, io4}, 8'h00);
    check({7'h00, rvalid}, 8'h00);
    check(rdata, 8'h00);
    repeat (4) @(negedge clock_i);
    rst_i = 1'b0;
    for (int k = 0; k < 6; k++)
      sh[k] = TABLE_RESET;
  endtask

  initial
  begin
    // a few hundred cycles are needed; allow ample margin
    #(25ns * 5000);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    rst_i      = 1'b1;
    req        = '0;
    up_mode    = logic_off;
    lo_mode    = logic_off;
    up_sel     = 3'h0;
    lo_sel     = 3'h0;
    for (int k = 0; k < 6; k++)
      sh[k] = TABLE_RESET;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    read_all();
    // enabled tables from reset drive io11 and io3 low; io12 and io4 stay undriven
    sweep(logic_three_one, logic_three_one);
    sh = '{8'h96, 8'h3C, 8'hE1, 8'h5A, 8'h0F, 8'hC3};
    // back-to-back writes
    write_burst();
    read_all();
    sweep(logic_three_one, logic_three_one);
    sweep(logic_three_two, logic_off);
    sweep(logic_off, logic_three_two);
    sweep(logic_other, logic_three_one);
    // tables survive modes that ignore them
    read_all();
    // unmapped accesses
    wr(8'h2C, 8'hFF);
    rd(8'h2C, UNMAPPED_READ);
    rd(8'h25, UNMAPPED_READ);
    read_all();
    // reset again: tables back to zero, enabled outputs low
    mid_reset();
    read_all();
    sweep(logic_three_one, logic_three_one);
    report_and_stop();
  end

endmodule // gpio_logic_lut_tb
